/* File: design/usm_pkg.sv */
package usm_pkg;

  localparam logic [7:0] ADDR_FLAGS    = 8'h0c;
  localparam logic [7:0] ADDR_RCV_CTL  = 8'h18;
  localparam logic [7:0] ADDR_TX_BUF   = 8'h19;
  localparam logic [7:0] ADDR_RX_FIFO  = 8'h1a;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h8c;
  localparam logic [7:0] ADDR_TX_CTL   = 8'h98;
  localparam logic [7:0] ADDR_RATE     = 8'h99;

  localparam int unsigned TXC_CLK_MASTER  = 7;
  localparam int unsigned TXC_NINTH_EN    = 6;
  localparam int unsigned TXC_TX_EN       = 5;
  localparam int unsigned TXC_SYNC        = 4;
  localparam int unsigned TXC_SHIFT_EMPTY = 1;
  localparam int unsigned TXC_NINTH_BIT   = 0;

  localparam int unsigned RXC_PORT_EN   = 7;
  localparam int unsigned RXC_NINTH_EN  = 6;
  localparam int unsigned RXC_SINGLE    = 5;
  localparam int unsigned RXC_CONT      = 4;
  localparam int unsigned RXC_OVERRUN   = 1;
  localparam int unsigned RXC_NINTH_BIT = 0;

  localparam int unsigned FLG_RX_FULL  = 5;
  localparam int unsigned FLG_TX_EMPTY = 4;

  localparam logic [7:0] TX_CTL_WMASK   = 8'hf5;
  localparam logic [7:0] RX_CTL_WMASK   = 8'hf0;
  localparam logic [7:0] IRQ_MASK_WMASK = 8'hbf;
  localparam logic [7:0] REG_RESET      = 8'h00;

  localparam logic [3:0] WORD_EIGHT = 4'h8;
  localparam logic [3:0] WORD_NINE  = 4'h9;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_TX   = 2'b01,
    MODE_RX   = 2'b10
  } usm_mode_e;

  function automatic logic [3:0] usm_word_len(input logic ninth);
    return ninth ? WORD_NINE : WORD_EIGHT;
  endfunction

endpackage

/* File: design/usm_top.sv */
// Operation
// - Half duplex: receiving inhibits transmission; receive enable takes the line even while transmitting.
// - Clocked mode bit selects synchronous; port enable turns pins into clock and data.
// - Clock source master bit makes the block drive the shift clock itself.
// - Shifter reloads from buffer only after last bit left, and at once.
// - Buffer to shifter move takes one cycle, then buffer empty flag sets.
// - Buffer empty flag ignores irq enable, software cannot clear, write clears it.
// - Shifter empty status is read only, set while shifter empty, no interrupt.
// - Transmit enable arms; first bit leaves on next rising shift clock edge.
// - Transmit data changes on rising edge, stable around the falling edge.
// - Rate generator held in reset while all enables clear; transmit enable starts it.
// - Write with empty shifter passes straight through, allowing gapless back-to-back words.
// - Clearing transmit enable aborts, resets transmitter, releases clock and data pins.
// - Receive enable suspends transmission mid-word, releases data, keeps clock, transmitter not reset.
// - Single receive clears itself after one word; transmit then resumes at once.
// - Ninth transmit enable picks nine-bit words; ninth bit taken at load time.
// - Single or continuous receive enables reception; data sampled on falling edge.
// - Single receives one word, continuous keeps going, continuous takes precedence.
// - Finished word moves into FIFO if room, then receive full flag sets.
// - Receive full flag read only, cleared when FIFO read empty.
// - Two words held; third finding FIFO full sets overrun and is discarded.
// - Overrun blocks FIFO transfers; cleared only by clearing continuous receive.
// - Ninth receive bit travels with each word; FIFO read advances it.
`timescale 1ns/1ps
module usm_top
  import usm_pkg::*;
#(
  parameter int unsigned RATE_PRESCALE = 4
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  output logic            o_sclk,
  output logic            o_sclk_oe,
  input  wire logic       i_sdat,
  output logic            o_sdat,
  output logic            o_sdat_oe
);

  localparam int CNT_W = $clog2(256 * RATE_PRESCALE);

  if (RATE_PRESCALE < 3) begin : g_check
    $error("RATE_PRESCALE must be at least 3 to cover the input synchroniser");
  end

  if (CNT_W > 31) begin : g_check_width
    $error("RATE_PRESCALE too large for the rate counter arithmetic");
  end

  function automatic logic [CNT_W-1:0] rate_reload(input logic [7:0] div);
    return CNT_W'((32'(div) + 32'd1) * RATE_PRESCALE - 32'd1);
  endfunction

  function automatic logic reg_hit(input logic stb, input logic [7:0] a, input logic [7:0] k);
    return stb && (a == k);
  endfunction

  logic [7:0]       tx_ctl_r,   tx_ctl_nxt;
  logic [7:0]       rx_ctl_r,   rx_ctl_nxt;
  logic [7:0]       mask_r,     mask_nxt;
  logic [7:0]       rate_r,     rate_nxt;
  logic [7:0]       txbuf_r,    txbuf_nxt;
  logic             full_r,     full_nxt;
  logic             transmit_buffer_empty_flag_r,     transmit_buffer_empty_flag_nxt;
  logic             transmit_enable_d_r,   transmit_enable_d_nxt;
  logic [8:0]       tsr_r,      tsr_nxt;
  logic [3:0]       left_r,     left_nxt;
  logic [8:0]       rsr_r,      rsr_nxt;
  logic [3:0]       rcnt_r,     rcnt_nxt;
  logic             overrun_error_r,     overrun_error_nxt;
  logic [8:0]       fifo_r      [2];
  logic [8:0]       fifo_nxt    [2];
  logic             rdp_r,      rdp_nxt;
  logic [1:0]       fcnt_r,     fcnt_nxt;
  logic [CNT_W-1:0] brg_r,      brg_nxt;
  logic             sclk_r,     sclk_nxt;
  logic             sdat_r,     sdat_nxt;
  logic             sdat_s1_r;
  logic             sdat_s2_r;
  usm_mode_e        mode_r,     mode_nxt;
  logic [7:0]       rdata_r,    rdata_nxt;

  logic             transmit_enable;
  logic             rx_en;
  logic             brg_run;
  logic             tick;
  logic             rise;
  logic             fall;
  logic             link_on;
  logic             load;
  logic             pop;
  logic             room;
  logic             wr_tx_buf;
  logic [8:0]       word_in;
  logic [8:0]       head;
  logic [3:0]       rx_len;

  always_comb begin
    tx_ctl_nxt = tx_ctl_r;
    rx_ctl_nxt = rx_ctl_r;
    mask_nxt   = mask_r;
    rate_nxt   = rate_r;
    txbuf_nxt  = txbuf_r;
    full_nxt   = full_r;
    transmit_buffer_empty_flag_nxt   = transmit_buffer_empty_flag_r;
    tsr_nxt    = tsr_r;
    left_nxt   = left_r;
    rsr_nxt    = rsr_r;
    rcnt_nxt   = rcnt_r;
    overrun_error_nxt   = overrun_error_r;
    fifo_nxt   = fifo_r;
    rdp_nxt    = rdp_r;
    fcnt_nxt   = fcnt_r;
    sdat_nxt   = sdat_r;
    rdata_nxt  = REG_RESET;
    word_in    = rsr_r;

    transmit_enable_d_nxt = transmit_enable;
    head       = fifo_r[rdp_r];
    rx_len     = usm_word_len(rx_ctl_r[RXC_NINTH_EN]);
    wr_tx_buf  = reg_hit(i_wr, i_addr, ADDR_TX_BUF);
    pop        = reg_hit(i_rd, i_addr, ADDR_RX_FIFO) && (fcnt_r != 2'h0);
    room       = (fcnt_r < FIFO_DEPTH) || pop;

    // Register writes.
    if (i_wr) begin
      case (i_addr)
        ADDR_TX_CTL: begin
          tx_ctl_nxt = (i_wdata & TX_CTL_WMASK) | (tx_ctl_r & ~TX_CTL_WMASK);
        end
        ADDR_RCV_CTL: begin
          rx_ctl_nxt = (i_wdata & RX_CTL_WMASK) | (rx_ctl_r & ~RX_CTL_WMASK);
          if (!i_wdata[RXC_CONT]) begin
            overrun_error_nxt = 1'b0;
          end
        end
        ADDR_IRQ_MASK: begin
          mask_nxt = i_wdata & IRQ_MASK_WMASK;
        end
        ADDR_RATE: begin
          rate_nxt = i_wdata;
        end
        default: begin
        end
      endcase
    end

    // Transmit buffer and shifter.
    load = transmit_enable && !rx_en && (left_r == 4'h0) && full_r;
    if (load) begin
      tsr_nxt  = {tx_ctl_r[TXC_NINTH_BIT], txbuf_r};
      left_nxt = usm_word_len(tx_ctl_r[TXC_NINTH_EN]);
      full_nxt = 1'b0;
    end
    if (wr_tx_buf) begin
      txbuf_nxt = i_wdata;
      full_nxt  = 1'b1;
    end
    if (wr_tx_buf) begin
      transmit_buffer_empty_flag_nxt = 1'b0;
    end else if (load) begin
      transmit_buffer_empty_flag_nxt = 1'b1;
    end else if (transmit_enable && !transmit_enable_d_r && !full_r) begin
      transmit_buffer_empty_flag_nxt = 1'b1;
    end
    if ((mode_r == MODE_TX) && rise && (left_r != 4'h0)) begin
      sdat_nxt = tsr_r[0];
      tsr_nxt  = {1'b0, tsr_r[8:1]};
      left_nxt = left_r - 4'h1;
    end
    if (!transmit_enable) begin
      left_nxt = 4'h0;
    end

    // Receive shifter, FIFO and overrun.
    if (!rx_en) begin
      rcnt_nxt = 4'h0;
      rsr_nxt  = 9'h000;
    end else if ((mode_r == MODE_RX) && fall) begin
      word_in[rcnt_r] = sdat_s2_r;
      if (!rx_ctl_r[RXC_NINTH_EN]) begin
        word_in[8] = 1'b0;
      end
      if (rcnt_r == rx_len - 4'h1) begin
        rcnt_nxt = 4'h0;
        rsr_nxt  = 9'h000;
        if (!overrun_error_r) begin
          if (room) begin
            fifo_nxt[rdp_r ^ fcnt_r[0]] = word_in;
          end else begin
            overrun_error_nxt = 1'b1;
          end
        end
        if (!rx_ctl_r[RXC_CONT]) begin
          rx_ctl_nxt[RXC_SINGLE] = 1'b0;
        end
      end else begin
        rsr_nxt  = word_in;
        rcnt_nxt = rcnt_r + 4'h1;
      end
    end
    fcnt_nxt = fcnt_r + {1'b0, (mode_r == MODE_RX) && fall && rx_en && (rcnt_r == rx_len - 4'h1)
                          && !overrun_error_r && room} - {1'b0, pop};
    rdp_nxt = rdp_r ^ pop;

    // Register reads, answered in the following cycle.
    if (i_rd) begin
      case (i_addr)
        ADDR_FLAGS: begin
          rdata_nxt[FLG_RX_FULL]  = (fcnt_r != 2'h0);
          rdata_nxt[FLG_TX_EMPTY] = transmit_buffer_empty_flag_r;
        end
        ADDR_RCV_CTL: begin
          rdata_nxt                = rx_ctl_r & RX_CTL_WMASK;
          rdata_nxt[RXC_OVERRUN]   = overrun_error_r;
          rdata_nxt[RXC_NINTH_BIT] = head[8];
        end
        ADDR_TX_BUF: begin
          rdata_nxt = txbuf_r;
        end
        ADDR_RX_FIFO: begin
          rdata_nxt = head[7:0];
        end
        ADDR_IRQ_MASK: begin
          rdata_nxt = mask_r;
        end
        ADDR_TX_CTL: begin
          rdata_nxt                  = tx_ctl_r & TX_CTL_WMASK;
          rdata_nxt[TXC_SHIFT_EMPTY] = (left_r == 4'h0);
        end
        ADDR_RATE: begin
          rdata_nxt = rate_r;
        end
        default: begin
          rdata_nxt = REG_RESET;
        end
      endcase
    end
  end

  assign transmit_enable  = tx_ctl_r[TXC_TX_EN];
  assign rx_en = rx_ctl_r[RXC_SINGLE] | rx_ctl_r[RXC_CONT];

  always_comb begin
    // Rate generator, stopped and held at its reload value with every enable off.
    brg_nxt  = brg_r;
    sclk_nxt = sclk_r;
    brg_run  = transmit_enable | rx_en;
    tick     = brg_run && (brg_r == '0);
    rise     = tick && !sclk_r;
    fall     = tick && sclk_r;
    if (!brg_run) begin
      brg_nxt  = rate_reload(rate_r);
      sclk_nxt = 1'b0;
    end else if (tick) begin
      brg_nxt  = rate_reload(rate_r);
      sclk_nxt = ~sclk_r;
    end else begin
      brg_nxt = brg_r - CNT_W'(1);
    end
  end

  always_comb begin
    // Line ownership of the two pins.
    mode_nxt = mode_r;
    link_on  = rx_ctl_r[RXC_PORT_EN] && tx_ctl_r[TXC_SYNC]
               && tx_ctl_r[TXC_CLK_MASTER];
    if (!link_on) begin
      mode_nxt = MODE_IDLE;
    end else if (rx_en) begin
      mode_nxt = MODE_RX;
    end else if (transmit_enable) begin
      mode_nxt = MODE_TX;
    end else begin
      mode_nxt = MODE_IDLE;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_ctl_r <= REG_RESET;
      rx_ctl_r <= REG_RESET;
      mask_r   <= REG_RESET;
      rate_r   <= REG_RESET;
    end else begin
      tx_ctl_r <= tx_ctl_nxt;
      rx_ctl_r <= rx_ctl_nxt;
      mask_r   <= mask_nxt;
      rate_r   <= rate_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      txbuf_r  <= REG_RESET;
      full_r   <= 1'b0;
      transmit_buffer_empty_flag_r   <= 1'b0;
      transmit_enable_d_r <= 1'b0;
      tsr_r    <= 9'h000;
      left_r   <= 4'h0;
      sdat_r   <= 1'b0;
    end else begin
      txbuf_r  <= txbuf_nxt;
      full_r   <= full_nxt;
      transmit_buffer_empty_flag_r   <= transmit_buffer_empty_flag_nxt;
      transmit_enable_d_r <= transmit_enable_d_nxt;
      tsr_r    <= tsr_nxt;
      left_r   <= left_nxt;
      sdat_r   <= sdat_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rsr_r  <= 9'h000;
      rcnt_r <= 4'h0;
      overrun_error_r <= 1'b0;
    end else begin
      rsr_r  <= rsr_nxt;
      rcnt_r <= rcnt_nxt;
      overrun_error_r <= overrun_error_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fifo_r[0] <= 9'h000;
      fifo_r[1] <= 9'h000;
      rdp_r     <= 1'b0;
      fcnt_r    <= 2'h0;
    end else begin
      fifo_r    <= fifo_nxt;
      rdp_r     <= rdp_nxt;
      fcnt_r    <= fcnt_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      brg_r  <= '0;
      sclk_r <= 1'b0;
    end else begin
      brg_r  <= brg_nxt;
      sclk_r <= sclk_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sdat_s1_r <= 1'b0;
      sdat_s2_r <= 1'b0;
    end else begin
      sdat_s1_r <= i_sdat;
      sdat_s2_r <= sdat_s1_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_r  <= MODE_IDLE;
      rdata_r <= REG_RESET;
    end else begin
      mode_r  <= mode_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata   = rdata_r;
  assign o_sclk    = sclk_r;
  assign o_sclk_oe = (mode_r != MODE_IDLE);
  assign o_sdat    = sdat_r;
  assign o_sdat_oe = (mode_r == MODE_TX);

endmodule

/* File: sim/usm_slave.sv */
`timescale 1ns/1ps
module usm_slave (
  input  wire logic        i_clk,
  input  wire logic        i_sclk,
  input  wire logic        i_line,
  input  wire logic        i_drv,
  input  wire logic        i_load,
  input  wire logic [8:0]  i_word,
  output logic             o_dat,
  output logic      [15:0] o_got
);
  logic       sclk_q = 1'b0;
  logic [8:0] rot;
  assign o_dat = rot[0];
  always_ff @(posedge i_clk) begin
    sclk_q <= i_sclk;
    if (i_load) begin
      rot <= i_word;
    end else if (sclk_q && !i_sclk && !i_drv) begin
      rot <= {rot[0], rot[8:1]}; // Next bit only after the falling sample.
    end
    if (sclk_q && !i_sclk && i_drv) begin
      o_got <= {i_line, o_got[15:1]}; // Taken at the falling edge, lsb first.
    end
  end
endmodule

/* File: sim/usm_assertions.sv */
`timescale 1ns/1ps
module usm_assertions
  import usm_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_rst_b,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       o_sclk,
  input wire logic       o_sclk_oe,
  input wire logic       i_sdat,
  input wire logic       o_sdat,
  input wire logic       o_sdat_oe
);
  logic cont_r;
  logic cont_nxt;
  logic port_r;
  logic port_nxt;
  always_comb begin
    cont_nxt = cont_r;
    port_nxt = port_r;
    if (i_wr && i_addr == ADDR_RCV_CTL) begin
      cont_nxt = i_wdata[RXC_CONT];
      port_nxt = i_wdata[RXC_PORT_EN];
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cont_r <= 1'b0;
      port_r <= 1'b0;
    end else begin
      cont_r <= cont_nxt;
      port_r <= port_nxt;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_tx_on;
    i_wr && i_addr == ADDR_TX_CTL && i_wdata[TXC_TX_EN] && i_wdata[TXC_SYNC]
      && i_wdata[TXC_CLK_MASTER] && port_r;
  endsequence
  sequence s_tx_off;
    i_wr && i_addr == ADDR_TX_CTL && !i_wdata[TXC_TX_EN];
  endsequence
  AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside answer cycle");
  AST_DATA_NEEDS_CLK: assert property (o_sdat_oe |-> o_sclk_oe)
    else $error("data driven without clock");
  AST_DATA_ON_RISE: assert property
    (o_sdat_oe && $past(o_sdat_oe) && $changed(o_sdat) |-> $rose(o_sclk))
    else $error("data changed off rising edge");
  AST_STABLE_AT_FALL: assert property ($fell(o_sclk) && o_sdat_oe |-> $stable(o_sdat))
    else $error("data moved at falling edge");
  AST_CLK_RELEASE: assert property ($fell(o_sclk_oe) |-> ##[0:2] !o_sclk)
    else $error("clock not low after release");
  AST_RX_NO_DRIVE: assert property (cont_r && $past(cont_r, 2) |-> !o_sdat_oe)
    else $error("data driven while receiving");
  AST_TXOFF_RELEASE: assert property (s_tx_off |-> ##[1:3] !o_sdat_oe)
    else $error("data not released");
  AST_TRANSMIT_ENABLE_CLK: assert property (s_tx_on |-> ##[1:3] o_sclk_oe)
    else $error("shift clock not started");
endmodule
bind usm_top usm_assertions u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_sclk(o_sclk),
  .o_sclk_oe(o_sclk_oe), .i_sdat(i_sdat), .o_sdat(o_sdat), .o_sdat_oe(o_sdat_oe));

/* File: sim/usm_top_bench.sv */
`timescale 1ns/1ps
module usm_top_bench;
  import usm_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [7:0]  o_rdata;
  logic        o_sclk;
  logic        o_sclk_oe;
  logic        o_sdat;
  logic        o_sdat_oe;
  logic        s_dat;
  logic        s_load = 1'b0;
  logic [8:0]  s_word = 9'h000;
  logic [15:0] s_got;
  int          n_errors = 0;
  int          n_tests = 0;
  wire         s_line = o_sdat_oe ? o_sdat : s_dat;
  always #2.5 i_clk = ~i_clk;
  usm_top uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_sclk(o_sclk), .o_sclk_oe(o_sclk_oe),
    .i_sdat(s_line), .o_sdat(o_sdat), .o_sdat_oe(o_sdat_oe));
  usm_slave u_slave (.i_clk(i_clk), .i_sclk(o_sclk), .i_line(s_line), .i_drv(o_sdat_oe),
    .i_load(s_load), .i_word(s_word), .o_dat(s_dat), .o_got(s_got));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                    input string what);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk({8'h00, o_rdata & m}, {8'h00, e}, what);
  endtask
  task automatic slv(input logic [8:0] w);
    @(posedge i_clk);
    s_word <= w;
    s_load <= 1'b1;
    @(posedge i_clk);
    s_load <= 1'b0;
  endtask
  task automatic t_regs();
    rc(ADDR_TX_CTL, 8'hff, 8'h02, "tx_ctl reset");
    wr(ADDR_FLAGS, 8'hff);
    rc(ADDR_FLAGS, 8'hff, 8'h00, "flags write");
    wr(ADDR_TX_CTL, 8'h10);
    rc(ADDR_TX_CTL, 8'hff, 8'h12, "tx_ctl sync");
    wr(ADDR_RATE, 8'h01);
    rc(ADDR_RATE, 8'hff, 8'h01, "rate");
    wr(ADDR_IRQ_MASK, 8'hff);
    rc(ADDR_IRQ_MASK, 8'hff, 8'hbf, "irq mask");
    rc(8'h55, 8'hff, 8'h00, "unmapped");
  endtask
  task automatic t_tx();
    wr(ADDR_RCV_CTL, 8'h80);
    wr(ADDR_TX_CTL, 8'h90);
    wr(ADDR_TX_BUF, 8'ha5);
    rc(ADDR_FLAGS, 8'h10, 8'h00, "flag held");
    wr(ADDR_TX_CTL, 8'hb0);
    rc(ADDR_FLAGS, 8'h10, 8'h10, "flag moved");
    wr(ADDR_TX_BUF, 8'h3c);
    rc(ADDR_FLAGS, 8'h10, 8'h00, "flag refill");
    rc(ADDR_TX_CTL, 8'h02, 8'h00, "shifter busy");
    repeat (16) @(negedge o_sclk);
    repeat (3) @(posedge i_clk);
    chk(s_got, 16'h3ca5, "two words");
    rc(ADDR_TX_CTL, 8'h02, 8'h02, "shifter empty");
    rc(ADDR_FLAGS, 8'h10, 8'h10, "flag after");
    wr(ADDR_TX_CTL, 8'h90);
  endtask
  task automatic t_tx9();
    time t0;
    wr(ADDR_TX_CTL, 8'hd1);
    wr(ADDR_TX_BUF, 8'h5a);
    wr(ADDR_TX_CTL, 8'hf1);
    @(posedge o_sclk);
    t0 = $time;
    @(posedge o_sclk);
    chk(16'($time - t0), 16'h0050, "sclk period");
    repeat (8) @(negedge o_sclk);
    repeat (3) @(posedge i_clk);
    chk({7'h00, s_got[15:7]}, 16'h015a, "nine bits");
    wr(ADDR_TX_BUF, 8'hff);
    repeat (2) @(negedge o_sclk);
    wr(ADDR_TX_CTL, 8'h90);
    repeat (3) @(posedge i_clk);
    chk({13'h0000, o_sclk_oe, o_sdat_oe, o_sclk}, 16'h0000, "abort pins");
    rc(ADDR_TX_CTL, 8'hff, 8'h92, "abort reset");
  endtask
  task automatic t_rx();
    slv(9'h1c3);
    wr(ADDR_RCV_CTL, 8'hd0);
    repeat (27) @(negedge o_sclk);
    repeat (4) @(posedge i_clk);
    rc(ADDR_FLAGS, 8'h20, 8'h20, "rx full");
    rc(ADDR_RCV_CTL, 8'hff, 8'hd3, "overrun");
    rc(ADDR_RX_FIFO, 8'hff, 8'hc3, "first word");
    rc(ADDR_RX_FIFO, 8'hff, 8'hc3, "second word");
    rc(ADDR_FLAGS, 8'h20, 8'h00, "fifo drained");
    repeat (9) @(negedge o_sclk);
    rc(ADDR_FLAGS, 8'h20, 8'h00, "pushes blocked");
    wr(ADDR_RCV_CTL, 8'h80);
    rc(ADDR_RCV_CTL, 8'hfe, 8'h80, "overrun cleared");
    slv(9'h0a5);
    wr(ADDR_RCV_CTL, 8'ha0);
    repeat (8) @(negedge o_sclk);
    repeat (12) @(posedge i_clk);
    chk({15'h0000, o_sclk}, 16'h0000, "single stop");
    rc(ADDR_RCV_CTL, 8'hfe, 8'h80, "single cleared");
    rc(ADDR_RX_FIFO, 8'hff, 8'ha5, "single word");
  endtask
  task automatic t_rx_abort();
    wr(ADDR_TX_CTL, 8'hb0);
    wr(ADDR_TX_BUF, 8'h81);
    @(posedge o_sclk);
    wr(ADDR_RCV_CTL, 8'ha0);
    repeat (3) @(posedge i_clk);
    chk({14'h0000, o_sclk_oe, o_sdat_oe}, 16'h0002, "rx takes line");
    repeat (8) @(negedge o_sclk);
    repeat (3) @(posedge i_clk);
    chk({15'h0000, o_sdat_oe}, 16'h0001, "tx resumes");
    wr(ADDR_TX_CTL, 8'h90);
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (8000) @(posedge i_clk);
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_regs();
    t_tx();
    t_tx9();
    t_rx();
    t_rx_abort();
    report_and_stop();
  end
endmodule
